//--- rtl/pin_edge_sync.sv
// Three-stage pin synchroniser with agreement filter and rising-edge pulse.
`timescale 1ns/1ps
`default_nettype none
module pin_edge_sync #(
  parameter int W = 24
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Pins and results
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out,
  output logic [W-1:0] rise_out
);
  logic [W-1:0] s1, s2, s3, prev;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A bit moves only when stages two and three agree.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      level_out <= '0;
      prev <= '0;
    end else begin
      level_out <= (s2 & s3) | (level_out & (s2 | s3));
      prev <= level_out;
    end
  end

  assign rise_out = level_out & ~prev; // see RULE18
endmodule // pin_edge_sync
`default_nettype wire

//--- rtl/remote_input_command_gate.sv
// Remote-input command gate: pin mapping, edge triggers, acceptance checks.
// Functional notes
// RULE1: Accept-active output shows remote control selected.
// RULE2: Act only on qualified rising edges.
// RULE3: Rejected edge raises error, command withheld.
// RULE4: Start needs ready, no faults, inputs idle.
// RULE5: Six weighted select bits form function number.
// RULE6: Stop edge aborts everything, unconditionally.
// RULE7: Pause accepted only while running.
// RULE8: Continue needs suspended, pause and stop low.
// RULE9: Manual-recovery continue, unassigned, no condition.
// RULE10: Reset clears halt and error when ready.
// RULE11: Forced reduced drive always honoured, blocks full.
// RULE12: Forced reduced drive stops or suspends by setting.
// RULE13: Robot select picks reported robot status.
// RULE14: Default map inputs 0-7, outputs 0-8.
// RULE15: Virtual I/O mode leaves processing active.
// RULE16: Rejection output unassigned until mapped.
// RULE17: Sequencer should clear errors before commanding.
// RULE18: Edges found against previous synchronised value.
// RULE19: Select bits latched with accepted start.
// RULE20: Alive input echoed on alive output.
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module remote_input_command_gate
  import remote_gate_pkg::*;
#(
  parameter int N_IN = NUM_IN,
  parameter int N_OUT = NUM_OUT
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rd_data_out,
  // Remote pins
  input wire logic [N_IN-1:0] remote_pins_in,
  output logic [N_OUT-1:0] remote_pins_out,
  // Controller status
  input wire logic ready_in,
  input wire logic error_in,
  input wire logic serious_error_in,
  input wire logic warning_in,
  input wire logic emergency_halt_active_in,
  input wire logic emergency_halt_cleared_in,
  input wire logic guard_open_in,
  input wire logic running_in,
  input wire logic suspended_in,
  input wire logic [1:0] drives_energized_in,
  input wire logic [1:0] at_rest_position_in,
  input wire logic [1:0] full_drive_level_in,
  input wire logic [1:0] calibration_needed_in,
  // Commands to controller
  output logic start_out,
  output logic [PSEL_W-1:0] main_function_out,
  output logic abort_out,
  output logic suspend_out,
  output logic resume_out,
  output logic resume_manual_recovery_out,
  output logic release_out,
  output logic forced_reduced_drive_out,
  output logic remote_accept_active_out,
  output logic command_rejected_out
);
  // ===========================================================
  // Register file
  logic [MAP_W-1:0] in_map [NFI];
  logic [MAP_W-1:0] out_map [NFO];
  logic [2:0] ctrl;
  logic [NFO*MAP_W-1:0] out_map_flat;
  logic [N_IN-1:0] pin_lvl, pin_rise;
  logic [NFI-1:0] fn_lvl, fn_rise;

  // Unassigned or out-of-range slots read as a quiet low pin.
  function automatic logic pick(input logic [N_IN-1:0] v, input logic [MAP_W-1:0] idx);
    pick = (32'(idx) < N_IN) ? v[idx] : 1'b0;
  endfunction

  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] base, input int n);
    wr_hit = a[7:6] == base[7:6] && a[1:0] == 2'h0 && 32'(a[5:2]) < n;
  endfunction

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < NFI; i++) begin
        in_map[i] <= IN_MAP_RST[i*MAP_W +: MAP_W]; // see RULE14
      end
    end else if (wr_in && wr_hit(addr_in, ADDR_IN_MAP, NFI)) begin
      in_map[addr_in[5:2]] <= wr_data_in[MAP_W-1:0]; // see RULE14
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < NFO; i++) begin
        out_map[i] <= OUT_MAP_RST[i*MAP_W +: MAP_W]; // see RULE16
      end
    end else if (wr_in && wr_hit(addr_in, ADDR_OUT_MAP, NFO)) begin
      out_map[addr_in[5:2]] <= wr_data_in[MAP_W-1:0];
    end
  end

  // The virtual I/O bit is stored only; processing never depends on it.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl <= CTRL_RST;
    end else if (wr_in && addr_in == ADDR_CTRL) begin
      ctrl <= wr_data_in[2:0]; // see RULE15
    end
  end

  // ===========================================================
  // Pin intake and function decode
  pin_edge_sync #(.W(N_IN)) u_sync (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .pin_in(remote_pins_in),
    .level_out(pin_lvl),
    .rise_out(pin_rise)
  );

  always_comb begin
    for (int i = 0; i < NFI; i++) begin
      fn_lvl[i] = pick(pin_lvl, in_map[i]);
      fn_rise[i] = pick(pin_rise, in_map[i]); // see RULE18
    end
  end

  // ===========================================================
  // Acceptance checks
  logic auto_mode, pause_lvl, stop_lvl, run_ok;
  logic ok_start, ok_pause, ok_cont, ok_reset;
  logic acc_start, acc_stop, acc_pause, acc_cont, acc_man, acc_reset;
  logic any_acc, any_rej, flow_rise, flow_prev;
  logic [PSEL_W-1:0] psel;

  assign auto_mode = ctrl[CTRL_REMOTE]; // see RULE1
  assign pause_lvl = fn_lvl[F_PAUSE];
  assign stop_lvl = fn_lvl[F_STOP];
  assign psel = fn_lvl[F_PSEL +: PSEL_W]; // see RULE5
  assign run_ok = ready_in && !error_in && !emergency_halt_active_in && !guard_open_in;

  assign ok_start = run_ok && emergency_halt_cleared_in && !pause_lvl && !stop_lvl; // see RULE4
  assign ok_pause = running_in; // see RULE7
  assign ok_cont = suspended_in && !pause_lvl && !stop_lvl; // see RULE8
  assign ok_reset = ready_in; // see RULE10

  assign acc_start = auto_mode && fn_rise[F_START] && ok_start; // see RULE2
  assign acc_stop = auto_mode && fn_rise[F_STOP]; // see RULE6
  assign acc_pause = auto_mode && fn_rise[F_PAUSE] && ok_pause;
  assign acc_cont = auto_mode && fn_rise[F_CONT] && ok_cont;
  assign acc_man = auto_mode && fn_rise[F_MANREC]; // see RULE9
  assign acc_reset = auto_mode && fn_rise[F_RESET] && ok_reset;
  assign any_acc = acc_start | acc_stop | acc_pause | acc_cont | acc_man | acc_reset;
  assign any_rej = auto_mode && ((fn_rise[F_START] && !ok_start) ||
                                 (fn_rise[F_PAUSE] && !ok_pause) ||
                                 (fn_rise[F_CONT] && !ok_cont) ||
                                 (fn_rise[F_RESET] && !ok_reset)); // see RULE3

  // Forced reduced drive ignores the remote selection entirely.
  assign flow_rise = fn_lvl[F_FLOW] && !flow_prev; // see RULE11

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flow_prev <= 1'b0;
    end else begin
      flow_prev <= fn_lvl[F_FLOW];
    end
  end

  // ===========================================================
  // Command pulses
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      start_out <= 1'b0;
      abort_out <= 1'b0;
      suspend_out <= 1'b0;
      resume_out <= 1'b0;
      resume_manual_recovery_out <= 1'b0;
      release_out <= 1'b0;
    end else begin
      start_out <= acc_start; // see RULE4
      abort_out <= acc_stop || (flow_rise && !ctrl[CTRL_FLOW_SUSPEND]); // see RULE6, RULE12
      suspend_out <= acc_pause || (flow_rise && ctrl[CTRL_FLOW_SUSPEND]); // see RULE7, RULE12
      resume_out <= acc_cont; // see RULE8
      resume_manual_recovery_out <= acc_man; // see RULE9
      release_out <= acc_reset; // see RULE10
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      main_function_out <= '0;
    end else if (acc_start) begin
      main_function_out <= psel; // see RULE19
    end
  end

  // A new rejection wins over a clear by an accepted command.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      command_rejected_out <= 1'b0;
    end else if (any_rej) begin
      command_rejected_out <= 1'b1; // see RULE3
    end else if (any_acc) begin
      command_rejected_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      forced_reduced_drive_out <= 1'b0;
      remote_accept_active_out <= 1'b0;
    end else begin
      forced_reduced_drive_out <= fn_lvl[F_FLOW]; // see RULE11
      remote_accept_active_out <= auto_mode; // see RULE1
    end
  end

  // ===========================================================
  // Status outputs onto pins
  logic rsel;
  logic [NFO-1:0] out_fn;

  assign rsel = fn_lvl[F_RSEL];

  always_comb begin
    out_fn = '0;
    out_fn[O_READY] = ready_in;
    out_fn[O_RUN] = running_in;
    out_fn[O_PAUSED] = suspended_in;
    out_fn[O_ERROR] = error_in;
    out_fn[O_AUTO] = auto_mode;
    out_fn[O_GUARD] = guard_open_in;
    out_fn[O_SERR] = serious_error_in;
    out_fn[O_WARN] = warning_in;
    out_fn[O_EHC] = emergency_halt_cleared_in;
    out_fn[O_REJ] = command_rejected_out; // see RULE16
    out_fn[O_ALIVE] = fn_lvl[F_ALIVE]; // see RULE20
    out_fn[O_DRV] = drives_energized_in[rsel]; // see RULE13
    out_fn[O_REST] = at_rest_position_in[rsel];
    out_fn[O_FULL] = full_drive_level_in[rsel] && !fn_lvl[F_FLOW]; // see RULE11
    out_fn[O_CAL] = calibration_needed_in[rsel];
  end

  always_comb begin
    for (int i = 0; i < NFO; i++) begin
      out_map_flat[i*MAP_W +: MAP_W] = out_map[i];
    end
  end

  status_router #(.NF(NFO), .NO(N_OUT)) u_route (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .func_in(out_fn),
    .map_in(out_map_flat),
    .pins_out(remote_pins_out)
  );

  // ===========================================================
  // Register reads, answered in the following cycle
  logic [31:0] next_rd;

  always_comb begin
    next_rd = 32'h0;
    if (wr_hit(addr_in, ADDR_IN_MAP, NFI)) begin
      next_rd = 32'(in_map[addr_in[5:2]]);
    end else if (wr_hit(addr_in, ADDR_OUT_MAP, NFO)) begin
      next_rd = 32'(out_map[addr_in[5:2]]);
    end else if (addr_in == ADDR_CTRL) begin
      next_rd = 32'(ctrl);
    end else if (addr_in == ADDR_STATUS) begin
      next_rd = {22'h0, main_function_out, forced_reduced_drive_out,
                 remote_accept_active_out, rsel, command_rejected_out};
    end else if (addr_in == ADDR_PINS) begin
      next_rd = 32'(pin_lvl);
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_data_out <= 32'h0;
    end else if (rd_in) begin
      rd_data_out <= next_rd;
    end else begin
      rd_data_out <= 32'h0;
    end
  end

  // ===========================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  property p_start_run;
    acc_start |=> start_out && main_function_out == $past(psel);
  endproperty
  a_start_run: assert property (p_start_run) else $error("start not issued"); // see RULE19

  property p_start_cond;
    start_out |-> $past(auto_mode && ready_in && !error_in && !emergency_halt_active_in && !guard_open_in &&
                        emergency_halt_cleared_in && !pause_lvl && !stop_lvl);
  endproperty
  a_start_cond: assert property (p_start_cond) else $error("start without its condition"); // see RULE4

  property p_reject;
    (auto_mode && fn_rise[F_START] && !ok_start) |=> command_rejected_out && !start_out;
  endproperty
  a_reject: assert property (p_reject) else $error("rejection missing"); // see RULE3

  property p_stop;
    (auto_mode && fn_rise[F_STOP]) |=> abort_out;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not honoured"); // see RULE6

  property p_pause;
    suspend_out && !$past(flow_rise) |-> $past(running_in && auto_mode);
  endproperty
  a_pause: assert property (p_pause) else $error("pause without running"); // see RULE7

  property p_cont;
    resume_out |-> $past(suspended_in && !pause_lvl && !stop_lvl);
  endproperty
  a_cont: assert property (p_cont) else $error("continue without suspension"); // see RULE8

  property p_reset;
    release_out |-> $past(ready_in);
  endproperty
  a_reset: assert property (p_reset) else $error("reset while not ready"); // see RULE10

  property p_flow;
    flow_rise |=> (abort_out != suspend_out) || $past(acc_stop || acc_pause);
  endproperty
  a_flow: assert property (p_flow) else $error("forced drive action wrong"); // see RULE12

  property p_no_auto;
    !auto_mode |=> !start_out && !resume_out && !release_out;
  endproperty
  a_no_auto: assert property (p_no_auto) else $error("command outside remote mode"); // see RULE1

  c_start: cover property (acc_start ##1 start_out);
  c_reject: cover property (any_rej ##1 command_rejected_out);
  c_flow: cover property (flow_rise ##1 suspend_out);
endmodule // remote_input_command_gate
`default_nettype wire

//--- rtl/status_router.sv
// Routes output functions onto physical output bits through a bit map.
`timescale 1ns/1ps
`default_nettype none
module status_router
  import remote_gate_pkg::*;
#(
  parameter int NF = 15,
  parameter int NO = 16
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Functions and map
  input wire logic [NF-1:0] func_in,
  input wire logic [NF*MAP_W-1:0] map_in,
  output logic [NO-1:0] pins_out
);
  logic [NO-1:0] next_pins;

  // Unassigned functions reach no pin; several may share one pin.
  always_comb begin
    next_pins = '0;
    for (int f = 0; f < NF; f++) begin
      for (int p = 0; p < NO; p++) begin
        if (map_in[f*MAP_W +: MAP_W] == MAP_W'(p) && func_in[f]) begin
          next_pins[p] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pins_out <= '0;
    end else begin
      pins_out <= next_pins;
    end
  end
endmodule // status_router
`default_nettype wire

//--- shared/remote_gate_pkg.sv
// Constants shared by the remote-input command gate.
package remote_gate_pkg;
  // ===========================================================
  // Pin counts and map fields
  localparam int NUM_IN = 24;
  localparam int NUM_OUT = 16;
  localparam int MAP_W = 5;
  localparam logic [4:0] MAP_NONE = 5'h1f;
  localparam int PSEL_W = 6;
  // ===========================================================
  // Input function slots
  localparam int F_START = 0;
  localparam int F_PSEL = 1;
  localparam int F_STOP = 7;
  localparam int F_PAUSE = 8;
  localparam int F_CONT = 9;
  localparam int F_MANREC = 10;
  localparam int F_RESET = 11;
  localparam int F_FLOW = 12;
  localparam int F_RSEL = 13;
  localparam int F_ALIVE = 14;
  localparam int NFI = 15;
  // ===========================================================
  // Output function slots
  localparam int O_READY = 0;
  localparam int O_RUN = 1;
  localparam int O_PAUSED = 2;
  localparam int O_ERROR = 3;
  localparam int O_AUTO = 4;
  localparam int O_GUARD = 5;
  localparam int O_SERR = 6;
  localparam int O_WARN = 7;
  localparam int O_EHC = 8;
  localparam int O_REJ = 9;
  localparam int O_ALIVE = 10;
  localparam int O_DRV = 11;
  localparam int O_REST = 12;
  localparam int O_FULL = 13;
  localparam int O_CAL = 14;
  localparam int NFO = 15;
  // ===========================================================
  // Reset maps, slot 0 in the low field
  localparam logic [NFI*MAP_W-1:0] IN_MAP_RST = {
    5'h1f, 5'h1f, 5'h1f, 5'h07, 5'h1f, 5'h06, 5'h05,
    5'h04, 5'h1f, 5'h1f, 5'h1f, 5'h03, 5'h02, 5'h01, 5'h00};
  localparam logic [NFO*MAP_W-1:0] OUT_MAP_RST = {
    5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h08,
    5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00};
  // ===========================================================
  // Register offsets and control fields
  localparam logic [7:0] ADDR_IN_MAP = 8'h00;
  localparam logic [7:0] ADDR_OUT_MAP = 8'h40;
  localparam logic [7:0] ADDR_CTRL = 8'h80;
  localparam logic [7:0] ADDR_STATUS = 8'h84;
  localparam logic [7:0] ADDR_PINS = 8'h88;
  localparam int CTRL_REMOTE = 0;
  localparam int CTRL_FLOW_SUSPEND = 1;
  localparam int CTRL_VIRTUAL_IO = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
endpackage

//--- test/remote_sequencer.sv
// Sequencer model that drives the remote input pins of the gate.
`timescale 1ns/1ps
`default_nettype none
module remote_sequencer
  import remote_gate_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Remote pins
  output logic [NUM_IN-1:0] pins_out
);
  initial pins_out = '0;

  // ==========================================================
  // Pin control
  // Pins change just after an edge, as a real sequencer output would.
  task automatic set_pin(input int i, input logic v);
    @(posedge clk_in);
    pins_out[i] <= v;
  endtask

  // The reset pulse is held long enough to pass the input filter.
  task automatic clear_error();
    set_pin(7, 1'h1);
    repeat (8) @(posedge clk_in);
    set_pin(7, 1'h0);
  endtask
endmodule // remote_sequencer
`default_nettype wire

//--- test/testbench.sv
// Self-checking bench for the remote-input command gate.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import remote_gate_pkg::*;
;
  typedef struct {int pin; logic [6:0] st; logic ok;} row_t;
  // Status bits: ready, error, halt active, halt cleared, guard, running, suspended.
  localparam logic [6:0] GOOD = 7'h48;
  logic clk_in, rstn_in, wr, rd;
  logic [7:0] addr;
  logic [31:0] wr_data, rd_data;
  logic [NUM_IN-1:0] pins;
  logic [NUM_OUT-1:0] pins_o;
  logic [6:0] st;
  logic [1:0] drv;
  logic start, abort, susp, resume, manrec, rel, forced, active, rej;
  logic [PSEL_W-1:0] mainf;
  int err_total, total_checks, n;
  row_t rows [13] = '{'{0, GOOD, 1'h1}, '{0, 7'h68, 1'h0}, '{0, 7'h58, 1'h0}, '{0, 7'h40, 1'h0},
    '{0, 7'h4c, 1'h0}, '{0, 7'h08, 1'h0}, '{5, 7'h02, 1'h1}, '{5, GOOD, 1'h0}, '{6, 7'h01, 1'h1},
    '{6, GOOD, 1'h0}, '{7, 7'h40, 1'h1}, '{7, 7'h08, 1'h0}, '{4, 7'h00, 1'h1}};

  remote_input_command_gate u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr),
    .wr_data_in(wr_data), .wr_in(wr), .rd_in(rd), .rd_data_out(rd_data), .remote_pins_in(pins),
    .remote_pins_out(pins_o), .ready_in(st[6]), .error_in(st[5]), .serious_error_in(1'h0),
    .warning_in(1'h0), .emergency_halt_active_in(st[4]), .emergency_halt_cleared_in(st[3]),
    .guard_open_in(st[2]), .running_in(st[1]), .suspended_in(st[0]), .drives_energized_in(drv),
    .at_rest_position_in(2'h0), .full_drive_level_in(drv), .calibration_needed_in(2'h0),
    .start_out(start), .main_function_out(mainf), .abort_out(abort), .suspend_out(susp),
    .resume_out(resume), .resume_manual_recovery_out(manrec), .release_out(rel),
    .forced_reduced_drive_out(forced), .remote_accept_active_out(active),
    .command_rejected_out(rej));
  remote_sequencer u_seq (.clk_in(clk_in), .pins_out(pins));

  // ==========================================================
  // Clock and helpers
  initial begin
    clk_in = 1'h0;
    forever #12.5 clk_in = ~clk_in;
  end

  function automatic logic pulse_of(input int k);
    case (k)
      0: return start;
      4: return abort;
      5: return susp;
      6: return resume;
      7: return rel;
      default: return manrec;
    endcase
  endfunction

  task automatic chk_bit(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask

  task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    wr_data <= d;
    wr <= 1'h1;
    @(posedge clk_in);
    wr <= 1'h0;
    repeat (3) @(posedge clk_in);
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk_in);
    rd <= 1'h0;
    @(negedge clk_in);
    chk_word("rd_data", exp, rd_data);
  endtask

  // Pulses are counted across the fall too, so an edge taken twice shows.
  task automatic fire(input int pin, input int k, output int cnt);
    cnt = 0;
    u_seq.set_pin(pin, 1'h1);
    for (int c = 0; c < 18; c++) begin
      @(negedge clk_in);
      if (pulse_of(k) === 1'h1) cnt++;
      if (c == 12) u_seq.set_pin(pin, 1'h0);
    end
  endtask

  task automatic settle();
    repeat (8) @(posedge clk_in);
  endtask

  task automatic close_out();
    if (err_total == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge clk_in);
    err_total++;
    close_out();
  end

  // ==========================================================
  // Main sequence
  initial begin
    err_total = 0;
    total_checks = 0;
    rstn_in = 1'h0;
    addr = 8'h00;
    wr_data = 32'h0;
    wr = 1'h0;
    rd = 1'h0;
    st = GOOD;
    drv = 2'h0;
    repeat (6) @(posedge clk_in);
    rstn_in <= 1'h1;
    rd_reg(ADDR_CTRL, 32'h0);
    rd_reg(8'h1c, 32'h4);
    rd_reg(8'h60, 32'h8);
    rd_reg(8'h64, 32'h1f);
    rd_reg(8'h90, 32'h0);
    fire(0, 0, n);
    chk_bit("ignored_start", 1'h1, n == 0);
    wr_reg(ADDR_CTRL, 32'h5);
    chk_bit("active", 1'h1, active);
    chk_bit("pin_out4", 1'h1, pins_o[4]);
    chk_bit("pin_out0", 1'h1, pins_o[0]);
    foreach (rows[i]) begin
      @(posedge clk_in);
      st <= rows[i].st;
      fire(rows[i].pin, rows[i].pin, n);
      chk_bit("pulse", rows[i].ok, n == 1);
      chk_bit("rejected", !rows[i].ok, rej);
    end
    u_seq.set_pin(1, 1'h1);
    u_seq.set_pin(3, 1'h1);
    st <= GOOD;
    settle();
    fire(0, 0, n);
    chk_word("main_fn", 32'h5, {26'h0, mainf});
    u_seq.set_pin(3, 1'h0);
    settle();
    chk_word("main_fn_held", 32'h5, {26'h0, mainf});
    u_seq.set_pin(5, 1'h1);
    settle();
    fire(0, 0, n);
    chk_bit("start_paused", 1'h1, n == 0);
    u_seq.set_pin(5, 1'h0);
    rd_reg(ADDR_STATUS, 32'h55);
    chk_bit("rej_unmapped", 1'h0, pins_o[10]);
    wr_reg(8'h64, 32'ha);
    chk_bit("rej_mapped", 1'h1, pins_o[10]);
    u_seq.clear_error();
    settle();
    chk_bit("rej_cleared", 1'h0, rej);
    wr_reg(8'h28, 32'hb);
    st <= 7'h00;
    fire(11, 11, n);
    chk_bit("manual", 1'h1, n == 1);
    wr_reg(8'h38, 32'h9);
    wr_reg(8'h68, 32'h9);
    u_seq.set_pin(9, 1'h1);
    settle();
    chk_bit("alive_hi", 1'h1, pins_o[9]);
    u_seq.set_pin(9, 1'h0);
    settle();
    chk_bit("alive_lo", 1'h0, pins_o[9]);
    wr_reg(8'h34, 32'hc);
    wr_reg(8'h6c, 32'hd);
    wr_reg(8'h74, 32'he);
    drv <= 2'h2;
    settle();
    chk_bit("robot0", 1'h0, pins_o[13]);
    u_seq.set_pin(12, 1'h1);
    settle();
    chk_bit("robot1", 1'h1, pins_o[13]);
    wr_reg(8'h30, 32'h8);
    wr_reg(ADDR_CTRL, 32'h0);
    fire(8, 4, n);
    chk_bit("forced_abort", 1'h1, n == 1);
    wr_reg(ADDR_CTRL, 32'h2);
    fire(8, 5, n);
    chk_bit("forced_suspend", 1'h1, n == 1);
    u_seq.set_pin(8, 1'h1);
    settle();
    chk_bit("forced_level", 1'h1, forced);
    chk_bit("full_masked", 1'h0, pins_o[14]);
    u_seq.set_pin(8, 1'h0);
    settle();
    chk_bit("forced_off", 1'h0, forced);
    chk_bit("full_shown", 1'h1, pins_o[14]);
    close_out();
  end
endmodule // testbench
`default_nettype wire
